/* inc/qps_pkg.sv */
// Purpose: constants, states and carriers for the quad page program and suspend front end
// Assumes: serial clock mode 0/3, inputs sampled on the rising serial clock edge
// Notes: apart from OP_QUAD_PROG at the head, opcodes are grouped by how the busy/suspend gating treats them
package qps_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_QUAD_PROG = 8'h32;
  localparam logic [7:0] OP_SUSPEND_A = 8'h75;
  localparam logic [7:0] OP_SUSPEND_B = 8'hB0;
  localparam logic [7:0] OP_READ_0 = 8'h03;
  localparam logic [7:0] OP_READ_1 = 8'h0B;
  localparam logic [7:0] OP_READ_2 = 8'h3B;
  localparam logic [7:0] OP_READ_3 = 8'h6B;
  localparam logic [7:0] OP_READ_4 = 8'hEB;
  localparam logic [7:0] OP_READ_5 = 8'hE7;
  localparam logic [7:0] OP_BUF_READ = 8'hD4;
  localparam logic [7:0] OP_ERASE_0 = 8'h81;
  localparam logic [7:0] OP_ERASE_1 = 8'hDB;
  localparam logic [7:0] OP_ERASE_2 = 8'h20;
  localparam logic [7:0] OP_ERASE_3 = 8'h52;
  localparam logic [7:0] OP_ERASE_4 = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_0 = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_1 = 8'hC7;
  localparam logic [7:0] OP_BUF_WRITE = 8'h84;
  localparam logic [7:0] OP_PROG_0 = 8'h02;
  localparam logic [7:0] OP_PROG_1 = 8'hA2;

  // ==========================================================================
  // framing counts and reset values
  localparam logic [4:0] OPC_LAST_CLK = 5'h07;
  localparam logic [4:0] ADDR_LAST_CLK = 5'h17;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic CS_IDLE_RESET = 1'b1;

  // ==========================================================================
  // state enumerations
  typedef enum logic [1:0] {LK_OPC, LK_ADDR, LK_DATA, LK_HOLD} qps_phase_type;
  typedef enum logic [1:0] {SY_IDLE, SY_EVAL, SY_DECIDE} qps_sys_state_type;

  // ==========================================================================
  // frame result carried from the serial clock side to the system side
  typedef struct packed {
    logic [7:0] opcode;
    logic opc_full;
    logic [23:0] addr;
    logic addr_full;
    logic permitted;
    logic aligned;
    logic [8:0] nbytes;
  } qps_frame_type;

endpackage : qps_pkg

/* src/qps_ctrl.sv */
// Purpose: quad page program framing, suspend decode and busy/suspend command gating
// Assumes: link_clk only toggles while cs_n_pin is low; status flags come from the core
// Notes: the link side keeps its results after the frame so the system side can read them
`timescale 1ns/10ps

// ============================================================================
// serial clock side: shifts opcode, address and quad data into the page buffer
module qps_link (
  input wire logic link_clk,
  input wire logic cs_n_pin,
  input wire logic si_pin,
  input wire logic so_pin_in,
  input wire logic write_guard_io2_pin,
  input wire logic pause_io3_pin,
  input wire logic busy_flag,
  input wire logic program_suspended_flag,
  input wire logic erase_suspended_flag,
  output logic so_pin_out,
  output logic so_pin_oe,
  output qps_pkg::qps_frame_type frame,
  output logic [255:0][7:0] page_data,
  output logic [255:0] page_mask
);

  typedef struct packed {
    logic busy_meta;
    logic busy_sync;
    logic ps_meta;
    logic ps_sync;
    logic es_meta;
    logic es_sync;
    qps_pkg::qps_phase_type phase;
    logic [4:0] cnt;
    logic [23:0] shift;
    logic nib_hi;
    logic [3:0] hi;
    logic [7:0] wr_idx;
    qps_pkg::qps_frame_type res;
    logic [255:0][7:0] data;
    logic [255:0] mask;
  } qps_link_state_type;

  qps_link_state_type cur;
  qps_link_state_type next_cur;
  logic in_frame;
  logic oe;
  logic so_out;

  // ==========================================================================
  // gating of an opcode against the synchronised status flags
  function automatic logic gate(input logic [7:0] op, input logic busy,
                                input logic ps, input logic es);
    logic ok;
    ok = 1'b1;
    if (op == qps_pkg::OP_READ_0 || op == qps_pkg::OP_READ_1 ||
        op == qps_pkg::OP_READ_2 || op == qps_pkg::OP_READ_3 ||
        op == qps_pkg::OP_READ_4 || op == qps_pkg::OP_READ_5 ||
        op == qps_pkg::OP_BUF_READ) begin
      ok = !busy;
    end else if (op == qps_pkg::OP_ERASE_0 || op == qps_pkg::OP_ERASE_1 ||
                 op == qps_pkg::OP_ERASE_2 || op == qps_pkg::OP_ERASE_3 ||
                 op == qps_pkg::OP_ERASE_4 || op == qps_pkg::OP_CHIP_ERASE_0 ||
                 op == qps_pkg::OP_CHIP_ERASE_1) begin
      ok = !(busy || ps || es);
    end else if (op == qps_pkg::OP_PROG_0 || op == qps_pkg::OP_PROG_1 ||
                 op == qps_pkg::OP_QUAD_PROG || op == qps_pkg::OP_BUF_WRITE) begin
      // erase suspend lets these through; the address check stays with the core
      ok = !(busy || ps);
    end else if (op == qps_pkg::OP_SUSPEND_A || op == qps_pkg::OP_SUSPEND_B) begin
      // only a running program or erase can be suspended; idle makes it a no-op
      ok = busy;
    end
    return ok;
  endfunction : gate

  // ==========================================================================
  // next state: the first edge of a frame starts from cleared results
  always_comb begin
    qps_link_state_type base;
    logic [7:0] opc;
    base = cur;
    opc = 8'h00;
    if (!in_frame) begin
      base.phase = qps_pkg::LK_OPC;
      base.cnt = 5'h00;
      base.nib_hi = 1'b1;
      base.res = '0;
      base.mask = '0;
    end
    next_cur = base;
    next_cur.busy_meta = busy_flag;
    next_cur.busy_sync = cur.busy_meta;
    next_cur.ps_meta = program_suspended_flag;
    next_cur.ps_sync = cur.ps_meta;
    next_cur.es_meta = erase_suspended_flag;
    next_cur.es_sync = cur.es_meta;
    case (base.phase)
      qps_pkg::LK_OPC: begin
        // opcode on SI only, most significant bit first
        next_cur.shift = {base.shift[22:0], si_pin};
        next_cur.cnt = base.cnt + 5'h01;
        next_cur.res.aligned = 1'b0;
        if (base.cnt == qps_pkg::OPC_LAST_CLK) begin
          opc = {base.shift[6:0], si_pin};
          next_cur.cnt = 5'h00;
          next_cur.res.opcode = opc;
          next_cur.res.opc_full = 1'b1;
          next_cur.res.aligned = 1'b1;
          next_cur.res.permitted = gate(opc, cur.busy_sync, cur.ps_sync, cur.es_sync);
          // a refused program never reaches the address phase
          if (opc == qps_pkg::OP_QUAD_PROG && next_cur.res.permitted) begin
            next_cur.phase = qps_pkg::LK_ADDR;
          end else begin
            next_cur.phase = qps_pkg::LK_HOLD;
          end
        end
      end
      qps_pkg::LK_ADDR: begin
        // 24 address clocks, A23 first
        next_cur.shift = {base.shift[22:0], si_pin};
        next_cur.cnt = base.cnt + 5'h01;
        next_cur.res.aligned = (base.cnt[2:0] == qps_pkg::BYTE_LAST_BIT);
        if (base.cnt == qps_pkg::ADDR_LAST_CLK) begin
          next_cur.res.addr = {base.shift[22:0], si_pin};
          next_cur.res.addr_full = 1'b1;
          next_cur.wr_idx = {base.shift[6:0], si_pin};
          next_cur.phase = qps_pkg::LK_DATA;
          next_cur.nib_hi = 1'b1;
        end
      end
      qps_pkg::LK_DATA: begin
        if (base.nib_hi) begin
          // bits 7..4 on io3, io2, SO, SI
          next_cur.hi = {pause_io3_pin, write_guard_io2_pin, so_pin_in, si_pin};
          next_cur.nib_hi = 1'b0;
          next_cur.res.aligned = 1'b0;
        end else begin
          // bits 3..0 in the same lane order; older bytes at the same slot are
          // overwritten, so only the last 256 survive
          next_cur.data[base.wr_idx] = {base.hi, pause_io3_pin, write_guard_io2_pin,
                                        so_pin_in, si_pin};
          next_cur.mask[base.wr_idx] = 1'b1;
          next_cur.wr_idx = base.wr_idx + 8'h01;
          if (base.res.nbytes != qps_pkg::PAGE_BYTES) begin
            next_cur.res.nbytes = base.res.nbytes + 9'h001;
          end
          next_cur.nib_hi = 1'b1;
          next_cur.res.aligned = 1'b1;
        end
      end
      default: begin
        // other commands: only the byte boundary is tracked
        next_cur.cnt = {2'b00, base.cnt[2:0] + 3'h1};
        next_cur.res.aligned = (base.cnt[2:0] == qps_pkg::BYTE_LAST_BIT);
      end
    endcase
  end

  // ==========================================================================
  // link registers; no reset because the clock is absent between frames
  always_ff @(posedge link_clk) begin
    cur <= next_cur;
  end

  // ==========================================================================
  // frame marker and SO direction, cleared by chip select release
  always_ff @(posedge link_clk or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      in_frame <= 1'b0;
      oe <= 1'b0;
      so_out <= 1'b0;
    end else begin
      in_frame <= 1'b1;
      so_out <= 1'b0;
      if (!in_frame) begin
        oe <= 1'b1;
      end else if (cur.phase == qps_pkg::LK_ADDR && cur.cnt == qps_pkg::ADDR_LAST_CLK) begin
        oe <= 1'b0;
      end
    end
  end

  assign so_pin_oe = oe;
  assign so_pin_out = so_out;
  assign frame = cur.res;
  assign page_data = cur.data;
  assign page_mask = cur.mask;

endmodule : qps_link

// ============================================================================
// system clock side: acts on each finished frame
module qps_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n_pin,
  input wire logic si_pin,
  input wire logic so_pin_in,
  output logic so_pin_out,
  output logic so_pin_oe,
  input wire logic write_guard_io2_pin,
  input wire logic pause_io3_pin,
  input wire logic busy_flag,
  input wire logic program_suspended_flag,
  input wire logic erase_suspended_flag,
  input wire logic addr_protected,
  input wire logic [7:0] buf_rd_index,
  output logic cmd_done,
  output logic [7:0] cmd_opcode,
  output logic cmd_permitted,
  output logic prog_start,
  output logic [23:0] prog_addr,
  output logic [8:0] prog_count,
  output logic latch_clear,
  output logic suspend_req,
  output logic [7:0] buf_rd_data,
  output logic buf_rd_written
);

  typedef struct packed {
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    qps_pkg::qps_sys_state_type st;
    logic cmd_done;
    logic [7:0] cmd_opcode;
    logic cmd_permitted;
    logic prog_start;
    logic [23:0] prog_addr;
    logic [8:0] prog_count;
    logic latch_clear;
    logic suspend_req;
    logic [7:0] rd_data;
    logic rd_written;
  } qps_sys_type;

  qps_sys_type cur;
  qps_sys_type next_cur;
  qps_pkg::qps_frame_type frame;
  logic [255:0][7:0] page_data;
  logic [255:0] page_mask;

  qps_link u_link (
    .link_clk(link_clk),
    .cs_n_pin(cs_n_pin),
    .si_pin(si_pin),
    .so_pin_in(so_pin_in),
    .write_guard_io2_pin(write_guard_io2_pin),
    .pause_io3_pin(pause_io3_pin),
    .busy_flag(busy_flag),
    .program_suspended_flag(program_suspended_flag),
    .erase_suspended_flag(erase_suspended_flag),
    .so_pin_out(so_pin_out),
    .so_pin_oe(so_pin_oe),
    .frame(frame),
    .page_data(page_data),
    .page_mask(page_mask)
  );

  // ==========================================================================
  // frame end handling; link results are quiet once chip select is high and
  // stay so until the next frame, which a host cannot start within 4 cycles
  always_comb begin
    next_cur = cur;
    next_cur.cs_meta = cs_n_pin;
    next_cur.cs_sync = cur.cs_meta;
    next_cur.cs_prev = cur.cs_sync;
    next_cur.cmd_done = 1'b0;
    next_cur.prog_start = 1'b0;
    next_cur.latch_clear = 1'b0;
    next_cur.suspend_req = 1'b0;
    next_cur.rd_data = page_data[buf_rd_index];
    next_cur.rd_written = page_mask[buf_rd_index];
    case (cur.st)
      qps_pkg::SY_IDLE: begin
        if (cur.cs_sync && !cur.cs_prev) begin
          next_cur.st = qps_pkg::SY_EVAL;
        end
      end
      qps_pkg::SY_EVAL: begin
        next_cur.st = qps_pkg::SY_IDLE;
        next_cur.cmd_done = frame.opc_full;
        // a cut opcode leaves the last frame's result in place
        if (frame.opc_full) begin
          next_cur.cmd_opcode = frame.opcode;
          next_cur.cmd_permitted = frame.permitted;
        end
        if (frame.opc_full && frame.permitted && frame.aligned &&
            (frame.opcode == qps_pkg::OP_SUSPEND_A ||
             frame.opcode == qps_pkg::OP_SUSPEND_B)) begin
          next_cur.suspend_req = 1'b1;
        end
        // a refused program leaves the latch alone
        if (frame.opc_full && frame.permitted &&
            frame.opcode == qps_pkg::OP_QUAD_PROG) begin
          if (!frame.addr_full || !frame.aligned) begin
            next_cur.latch_clear = 1'b1;
          end else if (frame.nbytes != 9'h000) begin
            next_cur.prog_addr = frame.addr;
            next_cur.prog_count = frame.nbytes;
            next_cur.st = qps_pkg::SY_DECIDE;
          end
        end
      end
      qps_pkg::SY_DECIDE: begin
        // the protection check has seen prog_addr for one cycle
        next_cur.st = qps_pkg::SY_IDLE;
        next_cur.prog_start = !addr_protected;
      end
      default: begin
        next_cur.st = qps_pkg::SY_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // system registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cur <= '0;
      cur.cs_meta <= qps_pkg::CS_IDLE_RESET;
      cur.cs_sync <= qps_pkg::CS_IDLE_RESET;
      cur.cs_prev <= qps_pkg::CS_IDLE_RESET;
      cur.st <= qps_pkg::SY_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  assign cmd_done = cur.cmd_done;
  assign cmd_opcode = cur.cmd_opcode;
  assign cmd_permitted = cur.cmd_permitted;
  assign prog_start = cur.prog_start;
  assign prog_addr = cur.prog_addr;
  assign prog_count = cur.prog_count;
  assign latch_clear = cur.latch_clear;
  assign suspend_req = cur.suspend_req;
  assign buf_rd_data = cur.rd_data;
  assign buf_rd_written = cur.rd_written;

endmodule : qps_ctrl

/* tb/qps_ctrl_monitor.sv */
// Purpose: concurrent checks on the system-side outputs of qps_ctrl
// Assumes: one sys_clk domain, synchronous active-high rst
// Notes: link pins are judged by the bench; status flags are async, so gating is checked there
`timescale 1ns/10ps
module qps_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic addr_protected,
  input wire logic cmd_done,
  input wire logic [7:0] cmd_opcode,
  input wire logic cmd_permitted,
  input wire logic prog_start,
  input wire logic [8:0] prog_count,
  input wire logic latch_clear,
  input wire logic suspend_req
);
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic is_prog;
  logic is_susp;

  // ==========================================================================
  // decoded opcode classes of the last finished frame
  assign is_prog = cmd_opcode == qps_pkg::OP_QUAD_PROG;
  assign is_susp = cmd_opcode == qps_pkg::OP_SUSPEND_A || cmd_opcode == qps_pkg::OP_SUSPEND_B;

  // ==========================================================================
  // pulses, their causes and what a refusal must leave alone
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("cmd_done held past one cycle");
  a_start_pulse: assert property (prog_start |=> !prog_start)
    else $error("prog_start held past one cycle");
  a_start_cause: assert property (prog_start |-> $past(cmd_done) && cmd_permitted && is_prog)
    else $error("prog_start without a permitted quad program frame");
  a_start_count: assert property (prog_start |-> prog_count != 9'h000 && prog_count <= 9'h100)
    else $error("prog_count out of range at prog_start");
  a_start_due: assert property (cmd_done && cmd_permitted && is_prog && !latch_clear
    && !addr_protected && prog_count != 9'h000 |=> prog_start)
    else $error("complete quad program frame not started");
  a_protect_block: assert property (cmd_done && addr_protected |=> !prog_start)
    else $error("program started on a protected address");
  a_refused_quiet: assert property (cmd_done && !cmd_permitted
    |-> !latch_clear && !suspend_req ##1 !prog_start)
    else $error("refused command had a side effect");
  a_suspend_cmd: assert property (suspend_req |-> cmd_done && cmd_permitted && is_susp)
    else $error("suspend_req without a permitted suspend frame");
  a_clear_cmd: assert property (latch_clear |-> cmd_done && cmd_permitted && is_prog
    ##1 !prog_start)
    else $error("latch_clear on the wrong frame or followed by a start");
  a_result_hold: assert property (!cmd_done |-> $stable(cmd_opcode) && $stable(cmd_permitted))
    else $error("frame result changed without cmd_done");

  // ==========================================================================
  // main scenarios reached
  c_start: cover property (prog_start);
  c_suspend: cover property (suspend_req);
  c_clear: cover property (latch_clear);
endmodule : qps_ctrl_monitor

bind qps_ctrl qps_ctrl_monitor qps_ctrl_monitor_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .addr_protected(addr_protected),
  .cmd_done(cmd_done),
  .cmd_opcode(cmd_opcode),
  .cmd_permitted(cmd_permitted),
  .prog_start(prog_start),
  .prog_count(prog_count),
  .latch_clear(latch_clear),
  .suspend_req(suspend_req)
);

/* tb/qps_host_model.sv */
// Purpose: host serial controller that clocks one frame of lane words into the device
// Assumes: mode 0, 12 ns serial clock that stands still outside frames
// Notes: write latch and four lane enable are taken as already set by the host
`timescale 1ns/10ps
module qps_host_model (
  input wire logic so_pin_oe,
  output logic link_clk,
  output logic cs_n_pin,
  output logic si_pin,
  output logic so_drive,
  output logic write_guard_io2_pin,
  output logic pause_io3_pin
);
  logic oe_log[$];

  // ==========================================================================
  // idle levels: guard and pause lines rest high on their pull-ups
  initial begin
    link_clk = 1'b0;
    si_pin = 1'b0;
    so_drive = 1'b0;
    write_guard_io2_pin = 1'b1;
    pause_io3_pin = 1'b1;
    // a clean rising edge just after start clears the link frame marker, which has no reset
    #1;
    cs_n_pin = 1'b1;
  end

  // one frame; lane word is {io3, io2, so, si}; one lane word per serial clock
  task automatic run(input logic [3:0] lanes[$]);
    oe_log.delete();
    cs_n_pin = 1'b0;
    foreach (lanes[i]) begin
      {pause_io3_pin, write_guard_io2_pin, so_drive, si_pin} = lanes[i];
      #6;
      oe_log.push_back(so_pin_oe);
      link_clk = 1'b1;
      #6;
      link_clk = 1'b0;
    end
    #6;
    cs_n_pin = 1'b1;
    // released line has no pull-up, so show the opposite of the last value
    so_drive = ~so_drive;
    // guard and pause lines fall back to their pull-ups
    {pause_io3_pin, write_guard_io2_pin} = 2'b11;
  endtask : run
endmodule : qps_host_model

/* tb/qps_ctrl_tb.sv */
// Purpose: self-checking bench for qps_ctrl through whole host frames
// Assumes: 100 ns sys_clk, 12 ns serial clock from the host model
// Notes: pulses are collected over a fixed ten-cycle window after each frame
`timescale 1ns/10ps
module qps_ctrl_tb;
  logic sys_clk, rst, busy_flag, program_suspended_flag, erase_suspended_flag, addr_protected;
  logic link_clk, cs_n_pin, si_pin, so_drive, io2, io3, so_pin_in, so_pin_out, so_pin_oe;
  logic cmd_done, cmd_permitted, prog_start, latch_clear, suspend_req, buf_rd_written;
  logic s_done, s_start, s_clear, s_susp;
  logic [7:0] buf_rd_index, cmd_opcode, buf_rd_data;
  logic [23:0] prog_addr;
  logic [8:0] prog_count;
  logic [3:0] q[$];
  logic [7:0] ops[21] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'hE7, 8'hD4, 8'h81, 8'hDB, 8'h20,
    8'h52, 8'hD8, 8'h60, 8'hC7, 8'h84, 8'h02, 8'hA2, 8'h32, 8'h75, 8'hB0, 8'h05};
  logic [2:0] sts[4] = '{3'h0, 3'h6, 3'h3, 3'h1};
  int errors, comparisons;

  // ==========================================================================
  // SO wire: device drives it while enabled, otherwise the host side does
  assign so_pin_in = so_pin_oe ? so_pin_out : so_drive;
  qps_ctrl qps_ctrl_i (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .cs_n_pin(cs_n_pin),
    .si_pin(si_pin), .so_pin_in(so_pin_in), .so_pin_out(so_pin_out), .so_pin_oe(so_pin_oe),
    .write_guard_io2_pin(io2), .pause_io3_pin(io3), .busy_flag(busy_flag),
    .program_suspended_flag(program_suspended_flag), .erase_suspended_flag(erase_suspended_flag),
    .addr_protected(addr_protected), .buf_rd_index(buf_rd_index), .cmd_done(cmd_done),
    .cmd_opcode(cmd_opcode), .cmd_permitted(cmd_permitted), .prog_start(prog_start),
    .prog_addr(prog_addr), .prog_count(prog_count), .latch_clear(latch_clear),
    .suspend_req(suspend_req), .buf_rd_data(buf_rd_data), .buf_rd_written(buf_rd_written));
  qps_host_model qps_host_model_i (.so_pin_oe(so_pin_oe), .link_clk(link_clk),
    .cs_n_pin(cs_n_pin), .si_pin(si_pin), .so_drive(so_drive), .write_guard_io2_pin(io2),
    .pause_io3_pin(io3));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // compares, verdict and frame building
  task automatic chkb(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chkb
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // first n bits of v on SI only, most significant first
  task automatic add_bits(input logic [23:0] v, input int n);
    for (int i = 23; i > 23 - n; i--) q.push_back({3'b110, v[i]});
  endtask : add_bits
  task automatic add_data(input logic [7:0] b);
    q.push_back(b[7:4]);
    q.push_back(b[3:0]);
  endtask : add_data
  task automatic frame;
    qps_host_model_i.run(q);
    q.delete();
    {s_done, s_start, s_clear, s_susp} = 4'h0;
    repeat (10) begin
      @(posedge sys_clk);
      #1;
      {s_done, s_start, s_clear, s_susp} = {s_done, s_start, s_clear, s_susp} |
        {cmd_done, prog_start, latch_clear, suspend_req};
    end
  endtask : frame
  task automatic prog_hdr(input logic [23:0] a);
    add_bits({qps_pkg::OP_QUAD_PROG, 16'h0000}, 8);
    add_bits(a, 24);
  endtask : prog_hdr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic wr);
    @(posedge sys_clk);
    buf_rd_index <= idx;
    repeat (2) @(posedge sys_clk);
    #1;
    chkb("buf_rd_written", wr, buf_rd_written);
    if (wr) chk("buf_rd_data", 24'(exp), 24'(buf_rd_data));
  endtask : rd
  // outcome the gating table calls for, per opcode class
  function automatic logic allowed(input logic [7:0] op, input logic [2:0] f);
    case (op)
      8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hEB, 8'hE7, 8'hD4: return !f[2];
      8'h81, 8'hDB, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7: return f == 3'h0;
      8'h02, 8'hA2, 8'h32, 8'h84: return f[2:1] == 2'h0;
      8'h75, 8'hB0: return f[2];
      default: return 1'b1;
    endcase
  endfunction : allowed

  // ==========================================================================
  // watchdog: the whole run needs well under half a millisecond
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end

  initial begin
    {rst, busy_flag, program_suspended_flag, erase_suspended_flag, addr_protected} = 5'h10;
    buf_rd_index = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // every opcode class in idle, busy with program suspend, program and erase suspend together, and erase suspend alone
    foreach (sts[s]) foreach (ops[k]) begin
      @(posedge sys_clk);
      {busy_flag, program_suspended_flag, erase_suspended_flag} <= sts[s];
      add_bits({ops[k], 16'h0000}, 8);
      frame();
      chkb("cmd_done", 1'b1, s_done);
      chk("cmd_opcode", 24'(ops[k]), 24'(cmd_opcode));
      chkb("cmd_permitted", allowed(ops[k], sts[s]), cmd_permitted);
      chkb("suspend_req", sts[s][2] && (ops[k] == 8'h75 || ops[k] == 8'hB0), s_susp);
      // an accepted quad program cut after its opcode lacks its address
      chkb("latch_clear", ops[k] == 8'h32 && allowed(ops[k], sts[s]), s_clear);
    end
    $display("test gating done");
    @(posedge sys_clk);
    {busy_flag, program_suspended_flag, erase_suspended_flag} <= 3'h0;
    prog_hdr(24'h0000FE);
    add_data(8'hA5);
    add_data(8'h3C);
    add_data(8'h5A);
    frame();
    chkb("prog_start", 1'b1, s_start);
    chk("prog_addr", 24'h0000FE, prog_addr);
    chk("prog_count", 24'h3, 24'(prog_count));
    chkb("so_pin_oe addr", 1'b1, qps_host_model_i.oe_log[31]);
    chkb("so_pin_oe data", 1'b0, qps_host_model_i.oe_log[32]);
    chkb("so_pin_oe idle", 1'b0, so_pin_oe);
    chkb("so_pin_out", 1'b0, so_pin_out);
    rd(8'hFE, 8'hA5, 1'b1);
    rd(8'hFF, 8'h3C, 1'b1);
    rd(8'h00, 8'h5A, 1'b1);
    rd(8'h01, 8'h00, 1'b0);
    $display("test wrap done");
    prog_hdr(24'h000010);
    for (int i = 0; i < 256; i++) add_data(i[7:0]);
    add_data(8'hC3);
    frame();
    chk("prog_count", 24'h100, 24'(prog_count));
    rd(8'h10, 8'hC3, 1'b1);
    rd(8'h11, 8'h01, 1'b1);
    $display("test overflow done");
    prog_hdr(24'h000000);
    add_data(8'h81);
    q.push_back(4'h7);
    frame();
    chkb("latch_clear", 1'b1, s_clear);
    chkb("prog_start", 1'b0, s_start);
    add_bits({qps_pkg::OP_QUAD_PROG, 16'h0000}, 8);
    add_bits(24'h123456, 12);
    frame();
    chkb("latch_clear", 1'b1, s_clear);
    chkb("prog_start", 1'b0, s_start);
    $display("test abort done");
    @(posedge sys_clk);
    addr_protected <= 1'b1;
    prog_hdr(24'h000100);
    add_data(8'h66);
    frame();
    chkb("prog_start", 1'b0, s_start);
    chkb("latch_clear", 1'b0, s_clear);
    @(posedge sys_clk);
    {addr_protected, busy_flag} <= 2'h1;
    add_bits({qps_pkg::OP_SUSPEND_A, 16'h0000}, 7);
    frame();
    chkb("cmd_done", 1'b0, s_done);
    chkb("suspend_req", 1'b0, s_susp);
    $display("test protect and partial suspend done");
    tally_and_finish();
  end
endmodule : qps_ctrl_tb
